// ### src/ata_cmd_cfg.svh
// register map, opcodes, subcodes and reset values of the command dispatcher
`ifndef ATA_CMD_CFG_SVH
`define ATA_CMD_CFG_SVH
// ==========================================================================
// apb register byte offsets
`define A_FEAT     8'h00
`define A_COUNT    8'h04
`define A_LBA      8'h08
`define A_CMD      8'h0c
`define A_STATUS   8'h10
`define A_RESULT   8'h14
`define A_CONFIG   8'h18
`define A_MAXADDR  8'h1c
`define A_GEOM     8'h20
`define A_STBY     8'h24
`define A_MULT     8'h28
// ==========================================================================
// opcodes
`define OP_NOP     8'h00
`define OP_RDS     8'h20
`define OP_RDS_NR  8'h21
`define OP_RDS_X   8'h24
`define OP_RDMA_X  8'h25
`define OP_RNMAX_X 8'h27
`define OP_RDM_X   8'h29
`define OP_DIAG    8'h90
`define OP_GEOM    8'h91
`define OP_UCODE   8'h92
`define OP_IDLE2   8'h97
`define OP_RDM     8'hc4
`define OP_SETMULT 8'hc6
`define OP_RDMA    8'hc8
`define OP_RDMA_NR 8'hc9
`define OP_WDMA    8'hca
`define OP_WDMA_NR 8'hcb
`define OP_STBY_I  8'he0
`define OP_IDLE_I  8'he1
`define OP_STBY    8'he2
`define OP_IDLE    8'he3
`define OP_RBUF    8'he4
`define OP_CHKPWR  8'he5
`define OP_SLEEP   8'he6
`define OP_FLUSH   8'he7
`define OP_WBUF    8'he8
`define OP_RBUF_D  8'he9
`define OP_FLUSH_X 8'hea
`define OP_WBUF_D  8'heb
`define OP_IDENT   8'hec
`define OP_SETFEAT 8'hef
`define OP_RNMAX   8'hf8
`define OP_SETMAX  8'hf9
// ==========================================================================
// feature subcodes
`define SF_WC_EN   8'h02
`define SF_XMODE   8'h03
`define SF_APM_EN  8'h05
`define SF_SER_EN  8'h10
`define SF_RLA_DIS 8'h55
`define SF_WC_DIS  8'h82
`define SF_APM_DIS 8'h85
`define SF_SER_DIS 8'h90
`define SF_SER_DMA 8'h02
`define SF_SER_DIP 8'h03
`define SF_SER_SSP 8'h06
`define SF_SER_P2S 8'h07
`define SF_RLA_EN  8'haa
`define SF_REVERT  8'hcc
`define SM_SETPW   8'h01
`define SM_LOCK    8'h02
`define SM_UNLOCK  8'h03
`define SM_FREEZE  8'h04
// ==========================================================================
// power mode codes, limits and reset values
`define PM_STANDBY 8'h00
`define PM_IDLE    8'h80
`define PM_ACTIVE  8'hff
`define MULT_MAX   8'h80
`define W47_DEF    8'h10
`define NATIVE_MAX 32'h0fff_ffff
`endif

// ### src/ata_cmd_pkg.sv
// types shared by the command dispatcher
package ata_cmd_pkg;
  // ========================================================================
  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_EXEC  = 3'b001,
    S_XFER  = 3'b010,
    S_FLUSH = 3'b011,
    S_DIAG  = 3'b100
  } state_e;
  // data protocol handed to the transfer engine
  typedef enum logic [1:0] {
    P_NONE = 2'b00,
    P_PIO  = 2'b01,
    P_DMA  = 2'b10
  } proto_e;
  // source or sink of the transfer data
  typedef enum logic [1:0] {
    D_MEDIA = 2'b00,
    D_BUF   = 2'b01,
    D_IDENT = 2'b10,
    D_UCODE = 2'b11
  } src_e;
endpackage : ata_cmd_pkg

// ### src/ata_command_dispatcher.sv
// ata command decoder and dispatcher with apb register access
// Summary of operation
// - c8h/c9h decode as dma reads, cah/cbh as dma writes, alike.
// - e0h/e2h standby, e1h/e3h idle, e6h sleep; e5h reports power mode.
// - e7h/eah flush the write cache to media before completing.
// - e4h/e9h read the sector buffer out; e8h/ebh overwrite it.
// - efh subcodes control write cache, transfer mode, apm, look-ahead.
// - efh 10h/90h enable/disable the serial feature named by count.
// - efh cch enables reverting settings to power-on defaults.
// - f9h sets max address; subcodes 1-4 password, lock, unlock, freeze.
// - f8h and 27h return the native max address.
// - ech sends identification data to the host as data-in.
// - 92h length is lba low:count sectors of 512 bytes, zero allowed.
// - 90h runs internal diagnostics and reports the result.
// - e3h/97h idle with nonzero count enables standby timer; zero disables it.
// - e1h holds busy, enters idle, drops busy, raises interrupt.
// - 91h stores sectors per track and heads per cylinder.
// - opcode 00h always completes with command aborted.
// - dma read c8h/c9h moves 1 to 256 sectors, zero meaning 256.
// - pio read 20h/21h moves 1 to 256 sectors, zero meaning 256.
// - extended read 24h moves up to 65536 sectors, zero meaning 65536.
// - 25h uses the dma protocol.
// - read multiple interrupts once per block of word 59 size.
// - 29h uses last set-multiple size, else word 47 default.
`timescale 1ns/1ps
`include "ata_cmd_cfg.svh"
module ata_command_dispatcher
  import ata_cmd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata_q,
  output logic             pready_q,
  output logic             pslverr_q,
  output logic             intrq_q,
  output logic             xfer_go_q,
  output proto_e           xfer_proto_q,
  output src_e             xfer_src_q,
  output logic             xfer_write_q,
  output logic      [31:0] xfer_lba_q,
  output logic      [16:0] xfer_sectors_q,
  input  wire logic        xfer_sector,
  output logic             flush_req_q,
  input  wire logic        flush_ack,
  output logic             diag_req_q,
  input  wire logic        diag_done,
  input  wire logic [7:0]  diag_code,
  output logic      [7:0]  power_mode_q
);
  // ========================================================================
  // apb slave: no wait state; read data leaves a flop loaded at the end of setup
  state_e      st_q;
  logic [7:0]  feat_q, cmd_q, spt_q, heads_q, stby_q, mult_q, xmode_q;
  logic [15:0] count_q;
  logic [31:0] lba_q, result_q, maxaddr_q;
  logic        err_q, wc_q, rla_q, apm_q, revert_q, stby_en_q;
  logic [3:0]  ser_q;
  logic        mult_ok_q, pw_q, mlock_q, mfrz_q;
  logic [16:0] left_q;
  logic [7:0]  blk_q, inblk_q;
  logic        setup, acc, wr, hit;
  logic [31:0] rdata;
  logic [7:0]  blk47;
  logic [16:0] cnt8, cnt16;

  assign setup = psel & ~penable;
  assign acc   = psel & penable & pready_q;
  assign wr    = acc & pwrite;

  // read mux; unmapped addresses answer with pslverr
  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    unique case (paddr)
      `A_FEAT:    rdata = {24'h000000, feat_q};
      `A_COUNT:   rdata = {16'h0000, count_q};
      `A_LBA:     rdata = lba_q;
      `A_CMD:     rdata = {24'h000000, cmd_q};
      `A_STATUS:  rdata = {19'h0, mlock_q, mfrz_q, pw_q,
                           power_mode_q, err_q, st_q != S_IDLE};
      `A_RESULT:  rdata = result_q;
      `A_CONFIG:  rdata = {16'h0, xmode_q, ser_q,
                           revert_q, apm_q, rla_q, wc_q};
      `A_MAXADDR: rdata = maxaddr_q;
      `A_GEOM:    rdata = {16'h0000, heads_q, spt_q};
      `A_STBY:    rdata = {23'h0, stby_en_q, stby_q};
      `A_MULT:    rdata = {23'h0, mult_ok_q, mult_q};
      default:    hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= psel & ~pready_q;
      if (setup) begin
        prdata_q  <= pwrite ? 32'h0000_0000 : rdata;
        pslverr_q <= ~hit;
      end
    end
  end

  // taskfile registers; frozen while a command runs, host must wait
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      feat_q  <= 8'h00;
      count_q <= 16'h0000;
      lba_q   <= 32'h0000_0000;
    end else if (wr && st_q == S_IDLE) begin
      if (paddr == `A_FEAT)  feat_q  <= pwdata[7:0];
      if (paddr == `A_COUNT) count_q <= pwdata[15:0];
      if (paddr == `A_LBA)   lba_q   <= pwdata;
    end
  end

  // sector count decode: zero means the full range
  assign cnt8  = (count_q[7:0] == 8'h00) ? 17'h00100
                                         : {9'h000, count_q[7:0]};
  assign cnt16 = (count_q == 16'h0000) ? 17'h10000 : {1'b0, count_q};
  assign blk47 = mult_ok_q ? mult_q : `W47_DEF;

  // ========================================================================
  // command sequencer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      cmd_q <= 8'h00;
      err_q <= 1'b0;
      intrq_q <= 1'b0;
      xfer_go_q <= 1'b0;
      xfer_proto_q <= P_NONE;
      xfer_src_q <= D_MEDIA;
      xfer_write_q <= 1'b0;
      xfer_lba_q <= 32'h0000_0000;
      xfer_sectors_q <= 17'h00000;
      left_q <= 17'h00000;
      blk_q <= 8'h00;
      inblk_q <= 8'h00;
      flush_req_q <= 1'b0;
      diag_req_q <= 1'b0;
      power_mode_q <= `PM_ACTIVE;
      result_q <= 32'h0000_0000;
      wc_q <= 1'b1;
      rla_q <= 1'b1;
      apm_q <= 1'b0;
      revert_q <= 1'b0;
      ser_q <= 4'h0;
      xmode_q <= 8'h00;
      stby_en_q <= 1'b0;
      stby_q <= 8'h00;
      spt_q <= 8'h00;
      heads_q <= 8'h00;
      mult_ok_q <= 1'b0;
      mult_q <= 8'h00;
      pw_q <= 1'b0;
      mlock_q <= 1'b0;
      mfrz_q <= 1'b0;
      maxaddr_q <= `NATIVE_MAX;
    end else begin
      intrq_q   <= 1'b0;
      xfer_go_q <= 1'b0;
      unique case (st_q)
        S_IDLE: begin
          if (wr && paddr == `A_CMD) begin
            cmd_q <= pwdata[7:0];
            err_q <= 1'b0;
            st_q  <= S_EXEC;
          end
        end
        S_EXEC: begin
          // most commands finish here; data ones hand over to the engine
          intrq_q <= 1'b1;
          st_q    <= S_IDLE;
          xfer_lba_q <= lba_q;
          blk_q   <= 8'h00;
          inblk_q <= 8'h00;
          unique case (cmd_q)
            `OP_RDMA, `OP_RDMA_NR, `OP_WDMA, `OP_WDMA_NR: begin
              intrq_q <= 1'b0;
              st_q <= S_XFER;
              xfer_go_q <= 1'b1;
              xfer_proto_q <= P_DMA;
              xfer_src_q <= D_MEDIA;
              xfer_write_q <= cmd_q[1];
              xfer_sectors_q <= cnt8;
              left_q <= cnt8;
            end
            `OP_RDS, `OP_RDS_NR, `OP_RDS_X, `OP_RDMA_X, `OP_RDM,
            `OP_RDM_X: begin
              intrq_q <= 1'b0;
              st_q <= S_XFER;
              xfer_go_q <= 1'b1;
              xfer_src_q <= D_MEDIA;
              xfer_write_q <= 1'b0;
              // plain pio raises the interrupt every sector
              xfer_proto_q <= (cmd_q == `OP_RDMA_X) ? P_DMA : P_PIO;
              blk_q <= (cmd_q == `OP_RDMA_X) ? 8'h00
                     : (cmd_q == `OP_RDM || cmd_q == `OP_RDM_X) ? blk47
                     : 8'h01;
              if (cmd_q == `OP_RDS || cmd_q == `OP_RDS_NR ||
                  cmd_q == `OP_RDM) begin
                xfer_sectors_q <= cnt8;
                left_q <= cnt8;
              end else begin
                xfer_sectors_q <= cnt16;
                left_q <= cnt16;
              end
            end
            `OP_RBUF, `OP_RBUF_D, `OP_WBUF, `OP_WBUF_D, `OP_IDENT: begin
              intrq_q <= 1'b0;
              st_q <= S_XFER;
              xfer_go_q <= 1'b1;
              xfer_src_q <= (cmd_q == `OP_IDENT) ? D_IDENT : D_BUF;
              xfer_proto_q <= (cmd_q == `OP_RBUF_D || cmd_q == `OP_WBUF_D)
                              ? P_DMA : P_PIO;
              xfer_write_q <= (cmd_q == `OP_WBUF || cmd_q == `OP_WBUF_D);
              xfer_sectors_q <= 17'h00001;
              left_q <= 17'h00001;
            end
            `OP_UCODE: begin
              // a zero length is legal and completes at once
              if ({lba_q[7:0], count_q[7:0]} != 16'h0000) begin
                intrq_q <= 1'b0;
                st_q <= S_XFER;
                xfer_go_q <= 1'b1;
                xfer_src_q <= D_UCODE;
                xfer_proto_q <= P_PIO;
                xfer_write_q <= 1'b1;
                xfer_sectors_q <= {1'b0, lba_q[7:0], count_q[7:0]};
                left_q <= {1'b0, lba_q[7:0], count_q[7:0]};
              end
            end
            `OP_STBY_I, `OP_STBY: power_mode_q <= `PM_STANDBY;
            `OP_IDLE_I: power_mode_q <= `PM_IDLE;
            `OP_IDLE, `OP_IDLE2: begin
              power_mode_q <= `PM_IDLE;
              stby_en_q <= count_q[7:0] != 8'h00;
              stby_q <= count_q[7:0];
            end
            `OP_SLEEP: power_mode_q <= `PM_STANDBY;
            `OP_CHKPWR: result_q <= {24'h000000, power_mode_q};
            `OP_FLUSH, `OP_FLUSH_X: begin
              intrq_q <= 1'b0;
              flush_req_q <= 1'b1;
              st_q <= S_FLUSH;
            end
            `OP_DIAG: begin
              intrq_q <= 1'b0;
              diag_req_q <= 1'b1;
              st_q <= S_DIAG;
            end
            `OP_GEOM: begin
              spt_q <= count_q[7:0];
              heads_q <= {4'h0, lba_q[27:24]} + 8'h01;
            end
            `OP_RNMAX, `OP_RNMAX_X: result_q <= `NATIVE_MAX;
            `OP_SETMULT: begin
              // only powers of two up to the limit are accepted
              if (count_q[7:0] != 8'h00 && count_q[7:0] <= `MULT_MAX &&
                  (count_q[7:0] & (count_q[7:0] - 8'h01)) == 8'h00) begin
                mult_q <= count_q[7:0];
                mult_ok_q <= 1'b1;
              end else begin
                err_q <= 1'b1;
              end
            end
            `OP_SETFEAT: begin
              unique case (feat_q)
                `SF_WC_EN:   wc_q <= 1'b1;
                `SF_WC_DIS:  wc_q <= 1'b0;
                `SF_XMODE:   xmode_q <= count_q[7:0];
                `SF_APM_EN:  apm_q <= 1'b1;
                `SF_APM_DIS: apm_q <= 1'b0;
                `SF_RLA_DIS: rla_q <= 1'b0;
                `SF_RLA_EN:  rla_q <= 1'b1;
                `SF_REVERT:  revert_q <= 1'b1;
                `SF_SER_EN, `SF_SER_DIS: begin
                  unique case (count_q[7:0])
                    `SF_SER_DMA: ser_q[0] <= ~feat_q[7];
                    `SF_SER_DIP: ser_q[1] <= ~feat_q[7];
                    `SF_SER_SSP: ser_q[2] <= ~feat_q[7];
                    `SF_SER_P2S: ser_q[3] <= ~feat_q[7];
                    default:     err_q <= 1'b1;
                  endcase
                end
                default: err_q <= 1'b1;
              endcase
            end
            `OP_SETMAX: begin
              unique case (feat_q)
                `SM_SETPW:  if (mfrz_q) err_q <= 1'b1;
                            else pw_q <= 1'b1;
                `SM_LOCK:   if (mfrz_q) err_q <= 1'b1;
                            else mlock_q <= 1'b1;
                `SM_UNLOCK: if (mfrz_q) err_q <= 1'b1;
                            else mlock_q <= 1'b0;
                `SM_FREEZE: mfrz_q <= 1'b1;
                default:    if (mlock_q || mfrz_q) err_q <= 1'b1;
                            else maxaddr_q <= lba_q;
              endcase
            end
            default: err_q <= 1'b1;
          endcase
        end
        S_XFER: begin
          // one interrupt per block when blk_q is nonzero, and always one at the end
          if (xfer_sector) begin
            left_q <= left_q - 17'h00001;
            inblk_q <= inblk_q + 8'h01;
            if (left_q == 17'h00001) begin
              intrq_q <= 1'b1;
              st_q <= S_IDLE;
            end else if (blk_q != 8'h00 &&
                         inblk_q + 8'h01 == blk_q) begin
              intrq_q <= 1'b1;
              inblk_q <= 8'h00;
            end
          end
        end
        S_FLUSH: begin
          // completion waits until the media side has the data
          if (flush_ack) begin
            flush_req_q <= 1'b0;
            intrq_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        S_DIAG: begin
          if (diag_done) begin
            diag_req_q <= 1'b0;
            result_q <= {24'h000000, diag_code};
            intrq_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ========================================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_nop;
    st_q == S_EXEC && cmd_q == `OP_NOP |=> err_q && intrq_q && st_q == S_IDLE;
  endproperty
  a_nop: assert property (p_nop) else $error("nop not aborted");

  property p_dma;
    st_q == S_EXEC && (cmd_q == `OP_RDMA || cmd_q == `OP_RDMA_NR) |=>
      xfer_go_q && xfer_proto_q == P_DMA && !xfer_write_q;
  endproperty
  a_dma: assert property (p_dma) else $error("dma read bad");

  property p_dma256;
    st_q == S_EXEC && cmd_q == `OP_RDMA && count_q[7:0] == 8'h00 |=>
      xfer_sectors_q == 17'h00100;
  endproperty
  a_dma256: assert property (p_dma256) else $error("count 0 not 256");

  property p_pio;
    st_q == S_EXEC && cmd_q == `OP_RDS |=> xfer_proto_q == P_PIO &&
      xfer_sectors_q == {8'h00, count_q[7:0] == 8'h00, count_q[7:0]};
  endproperty
  a_pio: assert property (p_pio) else $error("pio read bad");

  property p_ext;
    st_q == S_EXEC && cmd_q == `OP_RDS_X && count_q == 16'h0000 |=>
      xfer_sectors_q == 17'h10000;
  endproperty
  a_ext: assert property (p_ext) else $error("ext count bad");

  property p_rdmax;
    st_q == S_EXEC && cmd_q == `OP_RDMA_X |=> xfer_proto_q == P_DMA;
  endproperty
  a_rdmax: assert property (p_rdmax) else $error("25h not dma");

  property p_flush;
    st_q == S_FLUSH && !flush_ack |=> flush_req_q && !intrq_q;
  endproperty
  a_flush: assert property (p_flush) else $error("flush early");

  property p_idle_i;
    st_q == S_EXEC && cmd_q == `OP_IDLE_I |=>
      power_mode_q == `PM_IDLE && intrq_q && st_q == S_IDLE;
  endproperty
  a_idle_i: assert property (p_idle_i) else $error("idle imm bad");

  property p_wc;
    st_q == S_EXEC && cmd_q == `OP_SETFEAT && feat_q == `SF_WC_DIS |=> !wc_q;
  endproperty
  a_wc: assert property (p_wc) else $error("cache not off");

  property p_ident;
    st_q == S_EXEC && cmd_q == `OP_IDENT |=> xfer_go_q &&
      xfer_src_q == D_IDENT && !xfer_write_q;
  endproperty
  a_ident: assert property (p_ident) else $error("identify bad");

  property p_nmax;
    st_q == S_EXEC && cmd_q == `OP_RNMAX_X |=> result_q == `NATIVE_MAX;
  endproperty
  a_nmax: assert property (p_nmax) else $error("native max bad");

  c_dma: cover property (st_q == S_XFER && xfer_proto_q == P_DMA &&
                         xfer_sector && left_q == 17'h00001);
  c_blk: cover property (st_q == S_XFER && intrq_q);
  c_abort: cover property (err_q && intrq_q);
endmodule : ata_command_dispatcher

// ### verification/drive_backend_model.sv
// back end model: media sector engine, cache flush and self test
`timescale 1ns/1ps
module drive_backend_model #(
  parameter logic [7:0] DIAG_RES = 8'h01
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        xfer_go_q,
  input  wire logic [16:0] xfer_sectors_q,
  input  wire logic        flush_req_q,
  input  wire logic        diag_req_q,
  output logic             xfer_sector,
  output logic             flush_ack,
  output logic             diag_done,
  output logic      [7:0]  diag_code
);
  int left;
  int wt;
  // ==========================================================================
  // sector pump: stalls every other cycle once 300 or fewer remain, flat out above that
  always @(posedge core_clk) begin
    if (sys_rst) begin
      left <= 0;
      xfer_sector <= 1'b0;
    end else if (xfer_go_q === 1'b1) begin
      left <= int'(xfer_sectors_q);
      xfer_sector <= 1'b0;
    end else if (left > 0 && (left > 300 || !xfer_sector)) begin
      xfer_sector <= 1'b1;
      left <= left - 1;
    end else begin
      xfer_sector <= 1'b0;
    end
  end
  // media write-back and self test take a few cycles before answering
  always @(posedge core_clk) begin
    if (sys_rst || !(flush_req_q || diag_req_q)) wt <= 0;
    else wt <= wt + 1;
  end
  assign flush_ack = flush_req_q && wt == 5;
  assign diag_done = diag_req_q && wt == 3;
  // result lines show junk outside the done cycle, never the last value
  assign diag_code = diag_done ? DIAG_RES : ~DIAG_RES;
endmodule : drive_backend_model

// ### verification/tb_ata_command_dispatcher.sv
// self-checking bench for the ata command dispatcher
`timescale 1ns/1ps
`include "ata_cmd_cfg.svh"
module tb_ata_command_dispatcher
  import ata_cmd_pkg::*;
;
  typedef struct {
    logic [7:0] op;
    logic [7:0] c;
    int         n;
    proto_e     p;
    src_e       s;
    logic       w;
    int         irq;
  } job_s;
  logic        core_clk = 1'b0, sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, diag_code, power_mode_q;
  logic [31:0] pwdata = 32'h0, prdata_q, xfer_lba_q, rd, lba;
  logic [31:0] seed = 32'h399f;
  logic        pready_q, pslverr_q, intrq_q, xfer_go_q, xfer_write_q, er;
  logic        xfer_sector, flush_req_q, flush_ack, diag_req_q, diag_done;
  logic        ok;
  proto_e      xfer_proto_q;
  src_e        xfer_src_q;
  logic [16:0] xfer_sectors_q;
  logic [15:0] cfg;
  int          n_fail = 0, checks_done = 0, n_irq = 0, n_fl = 0;
  logic [7:0]  pops [5] = '{`OP_STBY_I, `OP_IDLE_I, `OP_STBY, `OP_IDLE,
                           `OP_SLEEP};
  logic [7:0]  sf [15] = '{8'h03, 8'h82, 8'h02, 8'h55, 8'haa, 8'h05, 8'h85,
                           8'h10, 8'h10, 8'h10, 8'h10, 8'h90, 8'hcc, 8'h77,
                           8'h10};
  logic [7:0]  sc [15] = '{8'h45, 0, 0, 0, 0, 0, 0, 8'h02, 8'h03, 8'h06,
                           8'h07, 8'h07, 0, 0, 8'h05};
  logic [7:0]  mf [7] = '{0, 1, 2, 0, 3, 4, 0};
  logic [2:0]  ms [7] = '{0, 1, 5, 5, 1, 3, 3};
  job_s        jobs [15] = '{
    '{`OP_RDMA, 0, 256, P_DMA, D_MEDIA, 0, 1},
    '{`OP_RDMA_NR, 1, 1, P_DMA, D_MEDIA, 0, 1},
    '{`OP_WDMA, 2, 2, P_DMA, D_MEDIA, 1, 1},
    '{`OP_WDMA_NR, 0, 256, P_DMA, D_MEDIA, 1, 1},
    '{`OP_RDS, 3, 3, P_PIO, D_MEDIA, 0, 3},
    '{`OP_RDS_NR, 0, 256, P_PIO, D_MEDIA, 0, 256},
    '{`OP_RDS_X, 0, 65536, P_PIO, D_MEDIA, 0, 65536},
    '{`OP_RDMA_X, 2, 2, P_DMA, D_MEDIA, 0, 1},
    '{`OP_RDM_X, 8'h20, 32, P_PIO, D_MEDIA, 0, 2},
    '{`OP_RBUF, 1, 0, P_PIO, D_BUF, 0, 1},
    '{`OP_RBUF_D, 1, 0, P_DMA, D_BUF, 0, 1},
    '{`OP_WBUF, 1, 0, P_PIO, D_BUF, 1, 1},
    '{`OP_WBUF_D, 1, 0, P_DMA, D_BUF, 1, 1},
    '{`OP_IDENT, 1, 0, P_PIO, D_IDENT, 0, 1},
    '{`OP_UCODE, 2, 258, P_PIO, D_UCODE, 1, 1}};

  ata_command_dispatcher u_ata_command_dispatcher (
    .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_q, .pready_q, .pslverr_q, .intrq_q, .xfer_go_q, .xfer_proto_q,
    .xfer_src_q, .xfer_write_q, .xfer_lba_q, .xfer_sectors_q, .xfer_sector,
    .flush_req_q, .flush_ack, .diag_req_q, .diag_done, .diag_code,
    .power_mode_q);
  drive_backend_model u_drive_backend_model (
    .core_clk, .sys_rst, .xfer_go_q, .xfer_sectors_q, .flush_req_q,
    .diag_req_q, .xfer_sector, .flush_ack, .diag_done, .diag_code);

  // ==========================================================================
  // clock, pulse counters and watchdog
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (intrq_q === 1'b1) n_irq++;
    if (flush_req_q === 1'b1 && flush_ack === 1'b1) n_fl++;
  end
  // the long extended read dominates the run time
  initial begin
    #4500000;
    n_fail++;
    conclude();
  end

  // ==========================================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one apb transfer; the request stands until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (pready_q !== 1'b1 && t < 20);
    if (t >= 20) n_fail++;
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // issue one command, poll busy, then count interrupts and the error flag
  task cmd(input logic [7:0] op, f, c, input logic [31:0] l,
           input int ni, input logic ee);
    int base;
    int t;
    apb(1'b1, `A_FEAT, {24'h0, f});
    apb(1'b1, `A_COUNT, {24'h0, c});
    apb(1'b1, `A_LBA, l);
    base = n_irq;
    apb(1'b1, `A_CMD, {24'h0, op});
    rd = 32'h1;
    t = 0;
    while (rd[0] !== 1'b0 && t < 30000) begin
      apb(1'b0, `A_STATUS, 32'h0);
      t++;
    end
    if (t >= 30000) n_fail++;
    repeat (3) @(posedge core_clk);
    chk("irq", ni, n_irq - base);
    chk("err", ee, rd[1]);
  endtask : cmd
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // ==========================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'b0, `A_CONFIG, 0);
    chk("config", 32'h3, rd & 32'h3);
    cmd(`OP_CHKPWR, 0, 0, 0, 1, 0);
    apb(1'b0, `A_RESULT, 0);
    chk("power", `PM_ACTIVE, rd);
    foreach (pops[i]) begin
      cmd(pops[i], 0, 0, 0, 1, 0);
      chk("mode", pops[i][0] ? `PM_IDLE : `PM_STANDBY, power_mode_q);
      chk("st mode", pops[i][0] ? `PM_IDLE : `PM_STANDBY, rd[9:2]);
    end
    cmd(`OP_CHKPWR, 0, 0, 0, 1, 0);
    apb(1'b0, `A_RESULT, 0);
    chk("power", `PM_STANDBY, rd);
    cmd(`OP_IDLE2, 0, 8'h05, 0, 1, 0);
    apb(1'b0, `A_STBY, 0);
    chk("stby", 32'h105, rd & 32'h1ff);
    cmd(`OP_IDLE, 0, 0, 0, 1, 0);
    apb(1'b0, `A_STBY, 0);
    chk("stby en", 0, rd[8]);
    $display("test power done");
    // set features against a model of the config word; bad codes abort
    cfg = 16'h0003;
    foreach (sf[i]) begin
      ok = 1'b1;
      case (sf[i])
        `SF_XMODE: cfg[15:8] = sc[i];
        `SF_WC_EN, `SF_WC_DIS: cfg[0] = !sf[i][7];
        `SF_RLA_DIS, `SF_RLA_EN: cfg[1] = sf[i][7];
        `SF_APM_EN, `SF_APM_DIS: cfg[2] = !sf[i][7];
        `SF_REVERT: cfg[3] = 1'b1;
        `SF_SER_EN, `SF_SER_DIS:
          if (sc[i] inside {8'h02, 8'h03, 8'h06, 8'h07})
            cfg[sc[i] < 4 ? sc[i] + 2 : sc[i]] = !sf[i][7];
          else ok = 1'b0;
        default: ok = 1'b0;
      endcase
      cmd(`OP_SETFEAT, sf[i], sc[i], 0, 1, !ok);
      apb(1'b0, `A_CONFIG, 0);
      chk("config", cfg, rd[15:0]);
    end
    $display("test features done");
    foreach (mf[i]) begin
      cmd(`OP_SETMAX, mf[i], 0, i == 0 ? 32'h200 : 32'h300, 1,
          mf[i] == 0 && i > 0);
      chk("max st", ms[i], rd[12:10]);
      apb(1'b0, `A_MAXADDR, 0);
      chk("maxaddr", 32'h200, rd);
    end
    foreach (pops[i]) if (i < 2) begin
      cmd(i ? `OP_RNMAX_X : `OP_RNMAX, 0, 0, 0, 1, 0);
      apb(1'b0, `A_RESULT, 0);
      chk("native", `NATIVE_MAX, rd);
    end
    $display("test max done");
    // data transfers with random start addresses
    foreach (jobs[i]) begin
      lba = jobs[i].op == `OP_UCODE ? 32'h1 : xs() & 32'h0fff_ffff;
      cmd(jobs[i].op, 0, jobs[i].c, lba, jobs[i].irq, 0);
      chk("proto", jobs[i].p, xfer_proto_q);
      chk("src", jobs[i].s, xfer_src_q);
      chk("dir", jobs[i].w, xfer_write_q);
      if (jobs[i].n > 0) chk("count", jobs[i].n, xfer_sectors_q);
      if (jobs[i].s == D_MEDIA) chk("lba", lba, xfer_lba_q);
    end
    cmd(`OP_UCODE, 0, 0, 0, 1, 0);
    cmd(`OP_SETMULT, 0, 8'h04, 0, 1, 0);
    cmd(`OP_SETMULT, 0, 8'h03, 0, 1, 1);
    apb(1'b0, `A_MULT, 0);
    chk("mult", 32'h104, rd & 32'h1ff);
    foreach (pops[i]) if (i < 2) begin
      cmd(i ? `OP_RDM_X : `OP_RDM, 0, 8'h08, 0, 2, 0);
      chk("count", 8, xfer_sectors_q);
    end
    $display("test transfers done");
    cmd(`OP_FLUSH, 0, 0, 0, 1, 0);
    cmd(`OP_FLUSH_X, 0, 0, 0, 1, 0);
    chk("flushes", 2, n_fl);
    cmd(`OP_DIAG, 0, 0, 0, 1, 0);
    apb(1'b0, `A_RESULT, 0);
    chk("diag", 32'h01, rd);
    cmd(`OP_GEOM, 0, 8'h3f, 32'h0500_0000, 1, 0);
    apb(1'b0, `A_GEOM, 0);
    chk("geom", 32'h063f, rd & 32'hffff);
    cmd(`OP_NOP, 0, 0, 0, 1, 1);
    cmd(8'h01, 0, 0, 0, 1, 1);
    apb(1'b0, 8'h40, 0);
    chk("slverr", 1, er);
    $display("test misc done");
    conclude();
  end
endmodule : tb_ata_command_dispatcher
